// File: dosc_params.svh
`ifndef DOSC_PARAMS_SVH
`define DOSC_PARAMS_SVH
// register offsets on the plain port
`define DOSC_ADDR_W 4
`define DOSC_OFF_CLKSEL 4'h0
`define DOSC_OFF_OSCCTL 4'h1
`define DOSC_OFF_CLOCK_RELOAD_DIVIDER 4'h2
`define DOSC_OFF_CKCON 4'h3
`define DOSC_OFF_CLKREG 4'h4
`define DOSC_OFF_STATUS 4'h5
`define DOSC_OFF_CAL 4'h6
// field positions
`define DOSC_BIT_CKS 0
`define DOSC_BIT_AEN 0
`define DOSC_BIT_BEN 1
`define DOSC_BIT_X2 0
// reset values
`define DOSC_CLOCK_RELOAD_DIVIDER_RST 8'hff
`define DOSC_TPS_RST 4'h5
`define DOSC_CLOCK_RELOAD_DIVIDER_OFF 8'hff
// fuse codes for the primary source
`define DOSC_A_HSXTAL 2'h3
`define DOSC_A_LPXTAL 2'h2
`define DOSC_A_EXT 2'h1
`define DOSC_A_RC 2'h0
// switchover: settle periods of each source
`define DOSC_SW_PERIODS 2'h2
// calibration locations
`define DOSC_CAL_USER_ADDR 16'h0180
`define DOSC_CAL_FACT_ADDR 16'h0008
`endif

// File: dosc_pkg.sv
package dosc_pkg;
   typedef enum logic [1:0] {
      DOSC_A_HS,
      DOSC_A_LP,
      DOSC_A_XCLK,
      DOSC_A_INTRC
   } dosc_asrc_t;
   typedef enum logic [1:0] {
      DOSC_B_XTAL,
      DOSC_B_XCLK,
      DOSC_B_INTRC
   } dosc_bsrc_t;
   typedef struct packed {
      logic [1:0] src_a;
      logic [1:0] src_b;
      logic osc_sel;
      logic x2;
   } dosc_fuse_t;
   typedef struct packed {
      logic a_en;
      logic b_en;
      logic system_clock_select;
   } dosc_ctl_t;
   typedef struct packed {
      logic p46_en;
      logic p47_en;
      logic p10_en;
      logic p42_en;
   } dosc_pins_t;
endpackage

// File: dosc_clock_select.sv
`timescale 1ns/1ps
// Function
// - primary source from two fuse bits: fast xtal, low-power xtal, external, rc
// - secondary source from fuses: upper bit 1 xtal, 01 external, 00 rc
// - primary crystal in use disables port 4.6 and 4.7
// - secondary crystal in use disables port 1.0 and 4.2
// - rc primary frees primary crystal pins as port 4.6 and 4.7
// - rc secondary frees secondary crystal pins as port 1.0 and 4.2
// - primary external: amplifier off, 4.7 usable or divided clock out
// - secondary external: amplifier off, 4.2 usable as port
// - rc trimmed by calibration byte from user signature location 0180h
// - factory calibration copy kept at signature address 0008h
// - optional halving, 8-bit reload divider, 4-bit peripheral prescaler
// - one source at a time by select bit, only to an enabled source
// - reset loads enables and select from the oscillator select fuse
// - switchover completes within two periods of each oscillator
// - disabling active oscillator or selecting disabled one is ignored
// - secondary source passes through same halving and divider
// - enabled oscillators keep running in idle
// - source select change blocked while idle
// - interrupt idle exit keeps bits; reset restores fuse defaults
// - select 0 routes secondary, select 1 routes primary
`include "dosc_params.svh"
module dosc_clock_select (
   input wire logic CLK,
   input wire logic RST_N,
   input wire dosc_pkg::dosc_fuse_t FUSE,
   input wire logic [7:0] CAL_USER,
   input wire logic [7:0] CAL_FACTORY,
   input wire logic PRIMARY_CLOCK_SOURCE_TICK,
   input wire logic SECONDARY_CLOCK_SOURCE_TICK,
   input wire logic IDLE,
   input wire logic [`DOSC_ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic AMP_A_EN,
   output logic AMP_A_HP,
   output logic AMP_B_EN,
   output logic RC_EN,
   output logic [7:0] RC_TRIM,
   output dosc_pkg::dosc_pins_t PORT_EN,
   output logic CLKOUT_A_AVAIL,
   output logic SYS_CLK,
   output logic PER_TICK
);
   ////////////////////////////////////////////////////////////////////////
   // decode of fuses
   dosc_pkg::dosc_asrc_t asrc;
   dosc_pkg::dosc_bsrc_t bsrc;
   always_comb begin
      case (FUSE.src_a)
         `DOSC_A_HSXTAL: asrc = dosc_pkg::DOSC_A_HS;
         `DOSC_A_LPXTAL: asrc = dosc_pkg::DOSC_A_LP;
         `DOSC_A_EXT: asrc = dosc_pkg::DOSC_A_XCLK;
         default: asrc = dosc_pkg::DOSC_A_INTRC;
      endcase
      if (FUSE.src_b[1]) begin
         bsrc = dosc_pkg::DOSC_B_XTAL;
      end else if (FUSE.src_b[0]) begin
         bsrc = dosc_pkg::DOSC_B_XCLK;
      end else begin
         bsrc = dosc_pkg::DOSC_B_INTRC;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // control bits; fuse is sampled by clock after reset release
   dosc_pkg::dosc_ctl_t ctl_q, ctl_d;
   logic loaded_q, loaded_d;
   logic [7:0] clock_reload_divider_q, clock_reload_divider_d;
   logic x2_q, x2_d;
   logic [3:0] tps_q, tps_d;
   logic [7:0] rdata_d;
   logic active_q;
   logic sw_busy_q;
   logic wr_sel, wr_osc;
   assign wr_sel = WR && ADDR == `DOSC_OFF_CLKSEL;
   assign wr_osc = WR && ADDR == `DOSC_OFF_OSCCTL;
   always_comb begin
      ctl_d = ctl_q;
      loaded_d = 1'b1;
      clock_reload_divider_d = clock_reload_divider_q;
      x2_d = x2_q;
      tps_d = tps_q;
      if (!loaded_q) begin
         ctl_d.a_en = FUSE.osc_sel;
         ctl_d.b_en = !FUSE.osc_sel;
         ctl_d.system_clock_select = FUSE.osc_sel;
         x2_d = !FUSE.x2;
      end else begin
         if (wr_osc) begin
            // the source driving the clock cannot be switched off
            ctl_d.a_en = WDATA[`DOSC_BIT_AEN] || ctl_q.system_clock_select || active_q;
            ctl_d.b_en = WDATA[`DOSC_BIT_BEN] || !ctl_q.system_clock_select || !active_q;
         end
         // select only to an enabled source, and never in idle
         if (wr_sel && !IDLE) begin
            if (WDATA[`DOSC_BIT_CKS] ? ctl_q.a_en : ctl_q.b_en) begin
               ctl_d.system_clock_select = WDATA[`DOSC_BIT_CKS];
            end
         end
         if (WR && ADDR == `DOSC_OFF_CLOCK_RELOAD_DIVIDER) begin
            clock_reload_divider_d = WDATA;
         end
         if (WR && ADDR == `DOSC_OFF_CKCON) begin
            x2_d = WDATA[`DOSC_BIT_X2];
         end
         if (WR && ADDR == `DOSC_OFF_CLKREG) begin
            tps_d = WDATA[7:4];
         end
      end
   end
   always_comb begin
      rdata_d = 8'h00;
      if (RD) begin
         case (ADDR)
            `DOSC_OFF_CLKSEL: rdata_d = {7'h00, ctl_q.system_clock_select};
            `DOSC_OFF_OSCCTL: rdata_d = {6'h00, ctl_q.b_en, ctl_q.a_en};
            `DOSC_OFF_CLOCK_RELOAD_DIVIDER: rdata_d = clock_reload_divider_q;
            `DOSC_OFF_CKCON: rdata_d = {7'h00, x2_q};
            `DOSC_OFF_CLKREG: rdata_d = {tps_q, 4'h0};
            `DOSC_OFF_STATUS: rdata_d = {5'h00, sw_busy_q, active_q, IDLE};
            `DOSC_OFF_CAL: rdata_d = CAL_USER;
            default: rdata_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctl_q <= '0;
         loaded_q <= 1'b0;
         clock_reload_divider_q <= `DOSC_CLOCK_RELOAD_DIVIDER_RST;
         x2_q <= 1'b0;
         tps_q <= `DOSC_TPS_RST;
      end else begin
         ctl_q <= ctl_d;
         loaded_q <= loaded_d;
         clock_reload_divider_q <= clock_reload_divider_d;
         x2_q <= x2_d;
         tps_q <= tps_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // glitch-free switchover: gate off old, wait periods of each, gate on new
   typedef enum logic [1:0] {SW_RUN, SW_DROP_OLD, SW_ARM_NEW} dosc_sw_t;
   dosc_sw_t sw_q, sw_d;
   logic active_d;
   logic [1:0] cnt_q, cnt_d;
   logic gate_q, gate_d;
   logic tick_old, tick_new;
   assign tick_old = active_q ? PRIMARY_CLOCK_SOURCE_TICK : SECONDARY_CLOCK_SOURCE_TICK;
   assign tick_new = active_q ? SECONDARY_CLOCK_SOURCE_TICK : PRIMARY_CLOCK_SOURCE_TICK;
   always_comb begin
      sw_d = sw_q;
      active_d = active_q;
      cnt_d = cnt_q;
      gate_d = gate_q;
      case (sw_q)
         SW_RUN: begin
            if (loaded_q && ctl_q.system_clock_select != active_q) begin
               sw_d = SW_DROP_OLD;
               gate_d = 1'b0;
               cnt_d = 2'h0;
            end
         end
         SW_DROP_OLD: begin
            if (tick_old) begin
               cnt_d = cnt_q + 2'h1;
            end
            if (cnt_q == `DOSC_SW_PERIODS - 2'h1 && tick_old) begin
               sw_d = SW_ARM_NEW;
               cnt_d = 2'h0;
            end
         end
         SW_ARM_NEW: begin
            if (tick_new) begin
               cnt_d = cnt_q + 2'h1;
            end
            if (cnt_q == `DOSC_SW_PERIODS - 2'h1 && tick_new) begin
               sw_d = SW_RUN;
               active_d = ctl_q.system_clock_select;
               gate_d = 1'b1;
            end
         end
         default: sw_d = SW_RUN;
      endcase
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_q <= SW_RUN;
         active_q <= 1'b0;
         cnt_q <= 2'h0;
         gate_q <= 1'b0;
      end else begin
         sw_q <= sw_d;
         // fuse default selection is taken as active without switchover
         active_q <= loaded_q ? active_d : FUSE.osc_sel;
         cnt_q <= cnt_d;
         gate_q <= loaded_q ? gate_d : 1'b1;
      end
   end
   assign sw_busy_q = sw_q != SW_RUN;
   ////////////////////////////////////////////////////////////////////////
   // shared halving and reload divider, then peripheral prescaler
   logic src_tick;
   logic half_q, half_d;
   logic [7:0] pre_q, pre_d;
   logic sys_q, sys_d;
   logic [3:0] tcnt_q, tcnt_d;
   logic per_d;
   logic stage_tick;
   // both sources share one path, so x2 and divider apply to either
   assign src_tick = gate_q && (active_q ? PRIMARY_CLOCK_SOURCE_TICK : SECONDARY_CLOCK_SOURCE_TICK);
   always_comb begin
      half_d = half_q;
      pre_d = pre_q;
      sys_d = sys_q;
      tcnt_d = tcnt_q;
      per_d = 1'b0;
      stage_tick = 1'b0;
      if (src_tick) begin
         half_d = !half_q;
         stage_tick = x2_q || half_q;
      end
      if (stage_tick) begin
         if (clock_reload_divider_q == `DOSC_CLOCK_RELOAD_DIVIDER_OFF) begin
            sys_d = !sys_q;
         end else if (pre_q == 8'hff) begin
            pre_d = clock_reload_divider_q;
            sys_d = !sys_q;
         end else begin
            pre_d = pre_q + 8'h01;
         end
      end
      if (stage_tick && sys_q) begin
         if (tcnt_q == 4'h0) begin
            tcnt_d = tps_q;
            per_d = 1'b1;
         end else begin
            tcnt_d = tcnt_q - 4'h1;
         end
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         half_q <= 1'b0;
         pre_q <= `DOSC_CLOCK_RELOAD_DIVIDER_RST;
         sys_q <= 1'b0;
         tcnt_q <= 4'h0;
         PER_TICK <= 1'b0;
      end else begin
         half_q <= half_d;
         pre_q <= pre_d;
         sys_q <= sys_d;
         tcnt_q <= tcnt_d;
         PER_TICK <= per_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // oscillator power and pin muxing; idle does not stop enabled oscillators
   logic a_xtal, b_xtal, a_on, b_on, rc_used;
   assign a_on = ctl_q.a_en || !loaded_q;
   assign b_on = ctl_q.b_en;
   assign a_xtal = asrc == dosc_pkg::DOSC_A_HS || asrc == dosc_pkg::DOSC_A_LP;
   assign b_xtal = bsrc == dosc_pkg::DOSC_B_XTAL;
   assign rc_used = (asrc == dosc_pkg::DOSC_A_INTRC && a_on) || (bsrc == dosc_pkg::DOSC_B_INTRC && b_on);
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AMP_A_EN <= 1'b0;
         AMP_A_HP <= 1'b0;
         AMP_B_EN <= 1'b0;
         RC_EN <= 1'b0;
         RC_TRIM <= 8'h00;
         PORT_EN <= '0;
         CLKOUT_A_AVAIL <= 1'b0;
         SYS_CLK <= 1'b0;
         RDATA <= 8'h00;
      end else begin
         AMP_A_EN <= a_xtal && a_on;
         AMP_A_HP <= asrc == dosc_pkg::DOSC_A_HS;
         AMP_B_EN <= b_xtal && b_on;
         RC_EN <= rc_used;
         // user byte trims; factory copy used if user byte erased
         RC_TRIM <= CAL_USER == 8'hff ? CAL_FACTORY : CAL_USER;
         PORT_EN.p46_en <= !(a_xtal && a_on) && asrc != dosc_pkg::DOSC_A_XCLK;
         PORT_EN.p47_en <= !(a_xtal && a_on);
         PORT_EN.p10_en <= !(b_xtal && b_on) && !(bsrc == dosc_pkg::DOSC_B_XCLK && b_on);
         PORT_EN.p42_en <= !(b_xtal && b_on);
         CLKOUT_A_AVAIL <= asrc == dosc_pkg::DOSC_A_XCLK;
         SYS_CLK <= sys_q;
         // one flop only, so read data stand in the cycle after the strobe
         RDATA <= rdata_d;
      end
   end
endmodule

// File: dosc_osc_model.sv
`timescale 1ns/1ps
module dosc_osc_model #(parameter int PER = 3) (
   input wire logic CLK,
   input wire logic RUN,
   output logic TICK
);
   int cnt = 0;
   initial TICK = 1'b0;
   // a stopped amplifier gives no edges, so no tick may leak out
   always @(posedge CLK) begin
      if (!RUN) begin
         cnt <= 0;
         TICK <= 1'b0;
      end else begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         TICK <= (cnt == PER - 1);
      end
   end
endmodule

// File: dosc_clock_select_properties.sv
`timescale 1ns/1ps
module dosc_chk (
   input wire logic CLK,
   input wire logic RST_N,
   input wire dosc_pkg::dosc_fuse_t FUSE,
   input wire logic [7:0] CAL_USER,
   input wire logic [7:0] CAL_FACTORY,
   input wire logic AMP_A_EN,
   input wire logic AMP_A_HP,
   input wire logic AMP_B_EN,
   input wire logic [7:0] RC_TRIM,
   input wire dosc_pkg::dosc_pins_t PORT_EN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_trim_pick: assert property ($stable(CAL_USER) && $stable(CAL_FACTORY) |=>
      RC_TRIM == (($past(CAL_USER) == 8'hff) ? $past(CAL_FACTORY) : $past(CAL_USER)))
      else $error("trim source wrong");
   a_hp_fast_only: assert property (AMP_A_HP |-> FUSE.src_a == 2'h3)
      else $error("high power amp without fast crystal");
   a_rc_a_amp: assert property (FUSE.src_a == 2'h0 |-> !AMP_A_EN)
      else $error("primary amp on with rc source");
   a_ext_a_amp: assert property (FUSE.src_a == 2'h1 |-> !AMP_A_EN)
      else $error("primary amp on with external clock");
   a_ext_b_amp: assert property (FUSE.src_b == 2'h1 |-> !AMP_B_EN)
      else $error("secondary amp on with external clock");
   a_rc_a_pins: assert property ($past(RST_N) && FUSE.src_a == 2'h0 |->
      PORT_EN.p46_en && PORT_EN.p47_en) else $error("primary pins not freed");
   a_rc_b_pins: assert property ($past(RST_N) && FUSE.src_b == 2'h0 |->
      PORT_EN.p10_en && PORT_EN.p42_en) else $error("secondary pins not freed");
   a_xtal_a_pins: assert property (FUSE.src_a[1] && AMP_A_EN && $past(AMP_A_EN) |->
      !PORT_EN.p46_en && !PORT_EN.p47_en) else $error("port on primary crystal pins");
   a_xtal_b_pins: assert property (FUSE.src_b[1] && AMP_B_EN && $past(AMP_B_EN) |->
      !(PORT_EN.p10_en || PORT_EN.p42_en)) else $error("port on secondary crystal pins");
   c_rc_pins: cover property (FUSE.src_a == 2'h0 && PORT_EN.p46_en);
   c_hp_amp: cover property (AMP_A_HP);
   c_xtal_b: cover property (FUSE.src_b[1] && AMP_B_EN);
endmodule
bind dosc_clock_select dosc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .FUSE(FUSE), .CAL_USER(CAL_USER),
   .CAL_FACTORY(CAL_FACTORY), .AMP_A_EN(AMP_A_EN), .AMP_A_HP(AMP_A_HP), .AMP_B_EN(AMP_B_EN),
   .RC_TRIM(RC_TRIM), .PORT_EN(PORT_EN));

// File: dual_oscillator_clock_select_tb_top.sv
`timescale 1ns/1ps
module dual_oscillator_clock_select_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic idle = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] cal_u = 8'h00;
   logic [7:0] cal_f = 8'h00;
   logic [7:0] rdata;
   logic tick_a, tick_b, amp_a, amp_b, rc_en, clkout, sys_clk;
   logic sys_prev = 1'b0;
   int toggles = 0;
   int t0;
   dosc_pkg::dosc_fuse_t fuse = '0;
   int err_total = 0;
   int n_tests = 0;
   int seed = 32'h48a9e190;
   int m_a, m_b, m_s, v;
   always #2.5 clk = ~clk;
   dosc_clock_select uut (.CLK(clk), .RST_N(rst_n), .FUSE(fuse), .CAL_USER(cal_u), .CAL_FACTORY(cal_f),
      .PRIMARY_CLOCK_SOURCE_TICK(tick_a), .SECONDARY_CLOCK_SOURCE_TICK(tick_b), .IDLE(idle), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .AMP_A_EN(amp_a), .AMP_A_HP(), .AMP_B_EN(amp_b), .RC_EN(rc_en), .RC_TRIM(),
      .PORT_EN(), .CLKOUT_A_AVAIL(clkout), .SYS_CLK(sys_clk), .PER_TICK());
   always @(posedge clk) begin
      sys_prev <= sys_clk;
      if (sys_clk !== sys_prev) toggles <= toggles + 1;
   end
   dosc_osc_model #(.PER(3)) u_osc_a (.CLK(clk), .RUN(amp_a || rc_en || fuse.src_a == 2'h1), .TICK(tick_a));
   dosc_osc_model #(.PER(7)) u_osc_b (.CLK(clk), .RUN(amp_b || rc_en || fuse.src_b == 2'h1), .TICK(tick_b));
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe is taken
   task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, rdata, e);
   endtask
   task automatic cmp_ctl();
      rc(4'h0, {7'h00, m_s[0]}, "select");
      rc(4'h1, {6'h00, m_b[0], m_a[0]}, "osc_ctl");
   endtask
   task automatic put_ctl(input logic [7:0] d);
      wr_reg(4'h1, d);
      m_a = d[0] || m_s == 1;
      m_b = d[1] || m_s == 0;
   endtask
   task automatic put_sel(input logic [7:0] d);
      wr_reg(4'h0, d);
      if (!idle && (d[0] ? m_a : m_b)) m_s = d[0];
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      for (int i = 0; i < 4; i++) begin
         rst_n <= 1'b0;
         fuse <= '{src_a: i[1:0], src_b: 2'h3 - i[1:0], osc_sel: i[0], x2: i[1]};
         cal_u <= (i == 2) ? 8'hff : 8'($random(seed));
         cal_f <= 8'($random(seed));
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         @(posedge clk);
         m_a = fuse.osc_sel;
         m_b = !fuse.osc_sel;
         m_s = fuse.osc_sel;
         cmp_ctl();
         rc(4'h3, {7'h00, !fuse.x2}, "double_speed");
         rc(4'h4, 8'h50, "prescaler");
         rc(4'h6, cal_u, "calibration");
         chk("clkout_avail", {7'h00, clkout}, {7'h00, fuse.src_a == 2'h1});
         rc(4'h8 + 4'(i), 8'h00, "unmapped");
         put_ctl(8'h00);
         put_sel(8'(!m_s));
         cmp_ctl();
         put_ctl(8'h03);
         idle <= 1'b1;
         put_sel(8'(!m_s));
         idle <= 1'b0;
         cmp_ctl();
         t0 = toggles;
         repeat (30) @(posedge clk);
         chk("sys_clk_runs", {7'h00, toggles > t0}, 8'h01);
         put_sel(8'(!m_s));
         // two periods of each source plus the register pipeline
         repeat (2 * 3 + 2 * 7 + 4) @(posedge clk);
         cmp_ctl();
         rc(4'h5, {6'h00, m_s[0], 1'b0}, "status");
         put_ctl({6'h00, m_s == 0, m_s == 1});
         cmp_ctl();
         idle <= 1'b1;
         cmp_ctl();
         idle <= 1'b0;
         v = $random(seed);
         wr_reg(4'h2, v[7:0]);
         rc(4'h2, v[7:0], "reload");
         $display("fuse case %0d done", i);
      end
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
